// ===== scd_top.sv
// Operation
// - DMA frame ends CRC, flag, then interrupt
// - Clear-to-send starts flags and first interrupt
// - Underrun with latch reset sends CRC, flag
// - Carrier loss or abort raises status interrupt
// - Overrun raises special condition, leaves DMA
// - Closing flag interrupts and drops receive request
// - Residue code reported in status at frame end
// - Error reset clears latched special condition
// - Four request outputs, one shared hold acknowledge
// - Both DMA: priority pin becomes B request
// - Vectored call, one byte per acknowledge
// - Bus inputs need no clock phase relation
// - Every-character mode: interrupt and request each
// - First-character mode: first gives both
// - Later characters give request only
// - Overrun special condition gives interrupt and request
// - DMA transmit empty gives request only
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module scd_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [scd_pkg::ADW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [scd_pkg::DW-1:0] WB_DAT_I,
  output logic [scd_pkg::DW-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Modem inputs per channel
  input wire logic [scd_pkg::NCH-1:0] CTS,
  input wire logic [scd_pkg::NCH-1:0] DCD,
  // Transmit serial core
  input wire logic [scd_pkg::NCH-1:0] TX_NEED,
  input wire logic [scd_pkg::NCH-1:0] TX_SENT,
  output logic [scd_pkg::NCH*8-1:0] TX_BYTE,
  output logic [scd_pkg::NCH-1:0] TX_SEND_FLAG,
  output logic [scd_pkg::NCH-1:0] TX_SEND_CRC,
  // Receive serial core
  input wire logic [scd_pkg::NCH-1:0] RX_CHAR,
  input wire logic [scd_pkg::NCH*8-1:0] RX_DATA,
  input wire logic [scd_pkg::NCH-1:0] RX_OVERRUN,
  input wire logic [scd_pkg::NCH-1:0] RX_FLAG,
  input wire logic [scd_pkg::NCH-1:0] RX_ABORT,
  input wire logic [scd_pkg::NCH*scd_pkg::RESW-1:0] RX_RESIDUE,
  // DMA requests: A tx, A rx, B tx, B rx
  output logic [2*scd_pkg::NCH-1:0] DMA_REQ,
  input wire logic HOLD_ACK_IN,
  // Interrupt and priority pin
  output logic INT_N,
  input wire logic INTERRUPT_ACK_N,
  input wire logic INTERRUPT_PRIORITY_IN,
  output logic CHAN_B_RX_DMA_REQ,
  output logic CHAN_B_RX_DMA_REQ_OE,
  // Vector byte to the CPU bus
  output logic [scd_pkg::VBW-1:0] VEC_DATA,
  output logic VEC_OE
);
  import scd_pkg::*;
  initial begin
    if (NCH != 2) $error("scd_top serves exactly two channels");
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // Synchronised bus inputs
  logic [2:0] sync_q;
  logic hold_ack_in;         // Hold acknowledge, high active
  logic ack_n_s;             // Interrupt acknowledge, low active
  logic pri_s;               // Priority pin level
  scd_sync #(.W(3), .RST(SYNC_RST)) u_sync (
    .CLK(CLK),
    .RESETN(RESETN),
    .D({INTERRUPT_PRIORITY_IN, INTERRUPT_ACK_N, HOLD_ACK_IN}),
    .Q(sync_q)
  );
  assign {pri_s, ack_n_s, hold_ack_in} = sync_q;

  // Per-channel registers
  logic [CTW-1:0] ctrl [NCH];
  scd_tx_e tx_st [NCH];
  logic [7:0] tbuf [NCH];
  logic [7:0] rbuf [NCH];
  logic [RESW-1:0] res [NCH];
  logic [STW-1:0] sts [NCH];
  logic tfull [NCH];         // Transmit buffer holds a byte
  logic end_of_message_latch [NCH];           // End-of-message latch; set means no auto CRC
  logic treq [NCH];
  logic rreq [NCH];
  logic spc [NCH];           // Special receive condition latched
  logic ovr [NCH];
  logic eof [NCH];
  logic ext [NCH];           // External/status interrupt pending
  logic txi [NCH];
  logic rxi [NCH];
  logic first [NCH];         // Armed for the next received character
  logic dcd_q [NCH];
  logic pend [NCH];

  // Bus slave state and strobes
  logic ack;
  logic [DW-1:0] dat;
  logic [VECW-1:0] vec;
  logic next_ack;
  logic [DW-1:0] next_dat;
  logic [VECW-1:0] next_vec;
  logic [NCH-1:0] wr_ctrl, wr_txd, rd_rxd, wr_sts;
  logic [CMDW-1:0] cmd;
  logic [DW-1:0] wm;         // Byte-lane write mask
  logic ch;
  logic [ADW-1:BLK_LSB] blk;

  // Decode one classic cycle; ack rises one edge after the strobe
  always_comb begin
    next_ack = WB_CYC_I & WB_STB_I & ~ack;
    next_dat = '0;
    next_vec = vec;
    wr_ctrl = '0;
    wr_txd = '0;
    rd_rxd = '0;
    wr_sts = '0;
    cmd = '0;
    wm = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    ch = WB_ADR_I[CH_BIT];
    blk = WB_ADR_I[ADW-1:BLK_LSB];
    if (next_ack) begin
      if (WB_ADR_I == A_CMD) begin
        // Commands are one-cycle pulses, nothing is stored
        if (WB_WE_I) cmd = WB_DAT_I[CMDW-1:0] & wm[CMDW-1:0];
      end else if (WB_ADR_I == A_VEC) begin
        next_dat[VECW-1:0] = vec;
        if (WB_WE_I) next_vec = (vec & ~wm[VECW-1:0]) | (WB_DAT_I[VECW-1:0] & wm[VECW-1:0]);
      end else if (blk == A_CTRL[ADW-1:BLK_LSB]) begin
        next_dat[CTW-1:0] = ctrl[ch];
        wr_ctrl[ch] = WB_WE_I & WB_SEL_I[0];
      end else if (blk == A_TXD[ADW-1:BLK_LSB]) begin
        next_dat[7:0] = tbuf[ch];
        wr_txd[ch] = WB_WE_I & WB_SEL_I[0];
      end else if (blk == A_RXD[ADW-1:BLK_LSB]) begin
        next_dat[7:0] = rbuf[ch];
        rd_rxd[ch] = ~WB_WE_I;
      end else if (blk == A_STS[ADW-1:BLK_LSB]) begin
        next_dat[STW-1:0] = sts[ch];
        wr_sts[ch] = WB_WE_I;
      end
      // Unmapped offsets still ack and read as zero
    end
  end

  // Bus registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack <= 1'b0;
      dat <= '0;
      vec <= VEC_RST;
    end else begin
      ack <= next_ack;
      dat <= next_dat;
      vec <= next_vec;
    end
  end
  assign WB_ACK_O = ack;
  assign WB_DAT_O = dat;

  // Channel logic, one copy per channel
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [CTW-1:0] next_ctrl;
    scd_tx_e next_tx;
    logic [7:0] next_tbuf, next_rbuf;
    logic [RESW-1:0] next_res;
    logic next_tfull, next_eom, next_treq, next_rreq, next_spc, next_ovr, next_eof;
    logic next_ext, next_txi, next_rxi, next_first, next_dcd;
    logic take;              // Serial core takes the buffered byte
    logic txen, tdma, rxen, rdma;
    logic [1:0] mode;
    logic [STW-1:0] clr;     // Write-one-to-clear mask for pending bits
    logic sflag, scrc;
    assign txen = ctrl[c][C_TXEN];
    assign tdma = ctrl[c][C_TXDMA];
    assign rxen = ctrl[c][C_RXEN];
    assign rdma = ctrl[c][C_RXDMA];
    assign mode = ctrl[c][C_MODE+1:C_MODE];
    assign clr = wr_sts[c] ? (WB_DAT_I[STW-1:0] & wm[STW-1:0]) : '0;

    // Next state: clears first, then events, so a set wins, except that a closing flag drops rreq last
    always_comb begin
      next_ctrl = wr_ctrl[c] ? WB_DAT_I[CTW-1:0] : ctrl[c];
      next_tx = tx_st[c];
      next_tbuf = tbuf[c];
      next_rbuf = rbuf[c];
      next_res = res[c];
      next_tfull = tfull[c];
      next_eom = end_of_message_latch[c];
      next_treq = treq[c];
      next_rreq = rreq[c];
      next_spc = spc[c];
      next_ovr = ovr[c];
      next_eof = eof[c];
      next_ext = ext[c] & ~clr[S_EXT];
      next_txi = txi[c] & ~clr[S_TXI];
      next_rxi = rxi[c] & ~clr[S_RXI];
      next_first = first[c] | cmd[K_NEXT+c];
      next_dcd = DCD[c];
      take = 1'b0;
      // Latch may be reset at any moment; best after the first byte
      if (cmd[K_EOM+c]) next_eom = 1'b0;
      if (cmd[K_ERR+c]) begin
        next_spc = 1'b0;
        next_ovr = 1'b0;
        next_eof = 1'b0;
      end
      // Only a transfer under hold acknowledge services a request
      if (wr_txd[c] && hold_ack_in) next_treq = 1'b0;
      if (rd_rxd[c] && hold_ack_in) next_rreq = 1'b0;
      // Transmitter
      case (tx_st[c])
        TX_OFF: begin
          if (txen && CTS[c]) begin
            next_tx = TX_FLAGS;
            next_ext = 1'b1;
          end
        end
        TX_FLAGS: begin
          // Waits for the CPU to load the address byte itself
          if (TX_NEED[c] && tfull[c]) begin
            next_tx = TX_DATA;
            take = 1'b1;
          end
        end
        TX_DATA: begin
          if (TX_NEED[c]) begin
            if (tfull[c]) begin
              take = 1'b1;
            end else if (!end_of_message_latch[c]) begin
              next_tx = TX_CRC;
              next_eom = 1'b1;
              next_ext = 1'b1;
            end else begin
              // Latch still set: no CRC, fall back to idle flags
              next_tx = TX_FLAGS;
            end
          end
        end
        TX_CRC: begin
          if (TX_SENT[c]) next_tx = TX_CLOSE;
        end
        default: begin
          if (TX_SENT[c]) begin
            next_tx = TX_FLAGS;
            next_txi = 1'b1;
          end
        end
      endcase
      if (!txen) next_tx = TX_OFF;
      if (take) begin
        next_tfull = 1'b0;
        if (tdma) next_treq = 1'b1;
        else next_txi = 1'b1;
      end
      // A write after a take refills the buffer in the same cycle
      if (wr_txd[c]) begin
        next_tbuf = WB_DAT_I[7:0];
        next_tfull = 1'b1;
      end
      // Receiver status events
      if (rxen && ((DCD[c] != dcd_q[c]) || RX_ABORT[c])) next_ext = 1'b1;
      if (RX_CHAR[c] && rxen) begin
        next_rbuf = RX_DATA[c*8 +: 8];
        // A latched special condition keeps the channel out of DMA
        if (!spc[c]) begin
          if (rdma) next_rreq = 1'b1;
          if (mode == RXM_EVERY) next_rxi = 1'b1;
          if (mode == RXM_FIRST && first[c]) begin
            next_rxi = 1'b1;
            next_first = 1'b0;
          end
        end
      end
      if (RX_OVERRUN[c]) begin
        next_spc = 1'b1;
        next_ovr = 1'b1;
        if (rdma) next_rreq = 1'b1;
      end
      if (RX_FLAG[c]) begin
        next_spc = 1'b1;
        next_eof = 1'b1;
        next_rreq = 1'b0;
        next_res = RX_RESIDUE[c*RESW +: RESW];
      end
    end

    // Channel registers
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        ctrl[c] <= CTRL_RST;
        tx_st[c] <= TX_OFF;
        tbuf[c] <= '0;
        rbuf[c] <= '0;
        res[c] <= '0;
        tfull[c] <= 1'b0;
        end_of_message_latch[c] <= EOM_RST;
        treq[c] <= 1'b0;
        rreq[c] <= 1'b0;
        spc[c] <= 1'b0;
        ovr[c] <= 1'b0;
        eof[c] <= 1'b0;
        ext[c] <= 1'b0;
        txi[c] <= 1'b0;
        rxi[c] <= 1'b0;
        first[c] <= 1'b0;
        dcd_q[c] <= 1'b0;
        sflag <= 1'b0;
        scrc <= 1'b0;
      end else begin
        ctrl[c] <= next_ctrl;
        tx_st[c] <= next_tx;
        tbuf[c] <= next_tbuf;
        rbuf[c] <= next_rbuf;
        res[c] <= next_res;
        tfull[c] <= next_tfull;
        end_of_message_latch[c] <= next_eom;
        treq[c] <= next_treq;
        rreq[c] <= next_rreq;
        spc[c] <= next_spc;
        ovr[c] <= next_ovr;
        eof[c] <= next_eof;
        ext[c] <= next_ext;
        txi[c] <= next_txi;
        rxi[c] <= next_rxi;
        first[c] <= next_first;
        dcd_q[c] <= next_dcd;
        sflag <= (next_tx == TX_FLAGS) || (next_tx == TX_CLOSE);
        scrc <= (next_tx == TX_CRC);
      end
    end

    // Status word, bit 0 upward: empty, latch, ext, spc, ovr, eof, residue, cts, dcd, txi, rxi
    assign sts[c] = {rxi[c], txi[c], DCD[c], CTS[c], res[c], eof[c], ovr[c], spc[c],
                     ext[c], end_of_message_latch[c], ~tfull[c]};
    assign pend[c] = (ext[c] & ctrl[c][C_EXTEN]) | txi[c] | rxi[c] | spc[c];
    assign TX_BYTE[c*8 +: 8] = tbuf[c];
    assign TX_SEND_FLAG[c] = sflag;
    assign TX_SEND_CRC[c] = scrc;
    assign DMA_REQ[2*c] = treq[c];
    assign DMA_REQ[2*c+1] = rreq[c];

    sequence s_crc_done;
      tx_st[c] == TX_CRC && TX_SENT[c] && txen;
    endsequence
    sequence s_close_done;
      tx_st[c] == TX_CLOSE && TX_SENT[c] && txen;
    endsequence
    AST_CRC_THEN_FLAG: assert property (s_crc_done |=> tx_st[c] == TX_CLOSE)
      else $error("closing flag did not follow CRC");
    AST_FRAME_END_INT: assert property (s_close_done |=> txi[c] && tx_st[c] == TX_FLAGS)
      else $error("no interrupt after closing flag");
    AST_CTS_START: assert property ((tx_st[c] == TX_OFF && txen && CTS[c])
      |=> (tx_st[c] == TX_FLAGS && ext[c])) else $error("flags not started on CTS");
    AST_UNDERRUN_CRC: assert property ((tx_st[c] == TX_DATA && TX_NEED[c] && !tfull[c]
      && !end_of_message_latch[c] && txen) |=> (tx_st[c] == TX_CRC && end_of_message_latch[c])) else $error("underrun sent no CRC");
    AST_TX_DMA_NOINT: assert property ((take && tdma && !txi[c])
      |=> (treq[c] && !txi[c])) else $error("DMA transmit empty raised an interrupt");
    AST_OVERRUN: assert property (RX_OVERRUN[c] |=> (spc[c] && ovr[c]))
      else $error("overrun not latched");
    AST_EOF_DROP: assert property (RX_FLAG[c] |=> (!rreq[c] && eof[c]
      && res[c] == $past(RX_RESIDUE[c*RESW +: RESW]))) else $error("end of frame mishandled");
    AST_ERR_RESET: assert property ((cmd[K_ERR+c] && !RX_OVERRUN[c] && !RX_FLAG[c])
      |=> !spc[c]) else $error("error reset left special condition");
    AST_EVERY_CHAR: assert property ((RX_CHAR[c] && rxen && !spc[c] && mode == RXM_EVERY
      && rdma && !RX_FLAG[c]) |=> (rxi[c] && rreq[c])) else $error("every-char mode miss");
    AST_LATER_CHAR: assert property ((RX_CHAR[c] && rxen && !spc[c] && mode == RXM_FIRST
      && !first[c] && !rxi[c] && rdma && !RX_FLAG[c]) |=> (!rxi[c] && rreq[c]))
      else $error("later character raised an interrupt");
    AST_REQ_HOLD: assert property ((treq[c] && !(wr_txd[c] && hold_ack_in)) |=> treq[c])
      else $error("transmit request dropped unserviced");
  end

  // Priority, interrupt line and vector cause
  logic both_dma, pri_act, any;
  logic int_n, pri_oe;
  logic next_int_n, next_pri_oe;
  logic [CODEW-1:0] cause;
  scd_vec_if vif ();
  assign both_dma = ctrl[0][C_RXDMA] & ctrl[1][C_RXDMA];
  // Pin doubles as B request, so priority is taken as held low
  assign pri_act = both_dma | ~pri_s;
  assign any = pend[0] | pend[1];

  // Channel A outranks B; within one, special over receive over status
  always_comb begin
    cause = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (spc[i]) cause = {i[0], T_SPC};
      else if (rxi[i]) cause = {i[0], T_RXI};
      else if (ext[i] & ctrl[i][C_EXTEN]) cause = {i[0], T_EXT};
      else if (txi[i]) cause = {i[0], T_TXI};
    end
    next_int_n = ~(any & pri_act);
    next_pri_oe = both_dma;
  end

  // Interrupt registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      int_n <= 1'b1;
      pri_oe <= 1'b0;
    end else begin
      int_n <= next_int_n;
      pri_oe <= next_pri_oe;
    end
  end
  assign INT_N = int_n;
  assign CHAN_B_RX_DMA_REQ_OE = pri_oe;
  assign CHAN_B_RX_DMA_REQ = rreq[1];

  assign vif.ack = ~ack_n_s;
  assign vif.enable = vec[V_EN];
  assign vif.base = {vec[VBW-1:CODEW], cause};
  scd_vec u_vec (
    .CLK(CLK),
    .RESETN(RESETN),
    .vif(vif)
  );
  assign VEC_DATA = vif.data;
  assign VEC_OE = vif.oe;

  AST_PRI_LOW: assert property ((both_dma && any) |=> (!INT_N && CHAN_B_RX_DMA_REQ_OE))
    else $error("both-DMA priority not taken low");
endmodule : scd_top

// ===== scd_pkg.sv
package scd_pkg;
  // Channel count and widths
  localparam int NCH = 2;
  localparam int ADW = 8;       // Byte address width seen by the slave
  localparam int DW = 32;       // Bus data width
  localparam int CTW = 8;       // Control register width
  localparam int CMDW = 6;      // Command register width
  localparam int STW = 13;      // Status register width
  localparam int RESW = 3;      // Residue code width
  localparam int VECW = 9;      // Vector register width
  localparam int VBW = 8;       // Vector byte width
  localparam int CODEW = 3;     // Cause code width folded into the vector
  localparam int CH_BIT = 2;    // Address bit that selects channel B
  localparam int BLK_LSB = 3;   // Lowest address bit of the block decode
  // Byte offsets; channel B sits four bytes above channel A
  localparam logic [ADW-1:0] A_CTRL = 8'h00;
  localparam logic [ADW-1:0] A_TXD = 8'h08;
  localparam logic [ADW-1:0] A_RXD = 8'h10;
  localparam logic [ADW-1:0] A_STS = 8'h18;
  localparam logic [ADW-1:0] A_CMD = 8'h20;
  localparam logic [ADW-1:0] A_VEC = 8'h24;
  // Control fields
  localparam int C_TXEN = 0;
  localparam int C_TXDMA = 1;
  localparam int C_RXEN = 2;
  localparam int C_RXDMA = 3;
  localparam int C_MODE = 4;    // Two bits: receive interrupt mode
  localparam int C_EXTEN = 6;
  localparam logic [1:0] RXM_FIRST = 2'h1;
  localparam logic [1:0] RXM_EVERY = 2'h2;
  // Command bits; channel B is one above channel A
  localparam int K_EOM = 0;
  localparam int K_ERR = 2;
  localparam int K_NEXT = 4;
  // Status fields
  localparam int S_EXT = 2;
  localparam int S_TXI = 11;
  localparam int S_RXI = 12;
  // Vector register: enable bit above the base byte
  localparam int V_EN = 8;
  // Cause codes, lowest priority first
  localparam logic [1:0] T_TXI = 2'h0;
  localparam logic [1:0] T_EXT = 2'h1;
  localparam logic [1:0] T_RXI = 2'h2;
  localparam logic [1:0] T_SPC = 2'h3;
  // Reset values
  localparam logic [CTW-1:0] CTRL_RST = 8'h00;
  localparam logic [VECW-1:0] VEC_RST = 9'h000;
  localparam logic EOM_RST = 1'b1;
  localparam logic [2:0] SYNC_RST = 3'h6; // Priority idle, ack idle, no hold
  // Call instruction bytes and their order
  localparam logic [VBW-1:0] CALL_OP = 8'hCD;
  localparam logic [VBW-1:0] CALL_HI = 8'h00;
  localparam logic [1:0] VB_OP = 2'h0;
  localparam logic [1:0] VB_LO = 2'h1;
  // Transmitter phases
  typedef enum logic [2:0] {TX_OFF, TX_FLAGS, TX_DATA, TX_CRC, TX_CLOSE} scd_tx_e;
endpackage : scd_pkg

// ===== scd_vec_if.sv
`timescale 1ns/1ps
interface scd_vec_if;
  import scd_pkg::*;
  logic ack;               // Acknowledge level, synchronised, high active
  logic enable;            // Vectored mode on
  logic [VBW-1:0] base;    // Vector byte with cause folded in
  logic [VBW-1:0] data;    // Byte driven for the current acknowledge
  logic oe;                // Byte is on the bus
  modport ctl (output ack, enable, base, input data, oe);
  modport seq (input ack, enable, base, output data, oe);
endinterface : scd_vec_if

// ===== scd_sync.sv
`timescale 1ns/1ps
module scd_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Asynchronous inputs and their synchronised copies
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  import scd_pkg::*;
  initial begin
    if (W < 1) $error("scd_sync needs at least one bit");
  end
  // Two flops per bit; the first is read only by the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta;
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        meta <= RST[i];
        Q[i] <= RST[i];
      end else begin
        meta <= D[i];
        Q[i] <= meta;
      end
    end
  end
endmodule : scd_sync

// ===== scd_vec.sv
`timescale 1ns/1ps
module scd_vec (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Acknowledge sequencing
  scd_vec_if.seq vif
);
  import scd_pkg::*;
  logic prev;              // Acknowledge level one cycle ago
  logic [1:0] idx;         // Which byte of the call comes next
  logic [VBW-1:0] data;
  logic oe;
  logic next_prev;
  logic [1:0] next_idx;
  logic [VBW-1:0] next_data;
  logic next_oe;
  // Each acknowledge start hands out one byte of the call
  always_comb begin
    next_prev = vif.ack;
    next_idx = idx;
    next_data = data;
    next_oe = vif.ack & vif.enable;
    if (vif.ack & ~prev & vif.enable) begin
      case (idx)
        VB_OP: begin
          next_data = CALL_OP;
          next_idx = VB_LO;
        end
        VB_LO: begin
          next_data = vif.base;
          next_idx = idx + 2'h1;
        end
        default: begin
          next_data = CALL_HI;
          next_idx = VB_OP;
        end
      endcase
    end
  end
  // Registers only
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      prev <= 1'b0;
      idx <= VB_OP;
      data <= '0;
      oe <= 1'b0;
    end else begin
      prev <= next_prev;
      idx <= next_idx;
      data <= next_data;
      oe <= next_oe;
    end
  end
  assign vif.data = data;
  assign vif.oe = oe;
  AST_CALL_FIRST: assert property (@(posedge CLK) disable iff (!RESETN)
    (vif.ack && !prev && vif.enable && idx == VB_OP) |=> (data == CALL_OP && idx == VB_LO))
    else $error("call opcode not first byte");
endmodule : scd_vec

// ===== scd_host_model.sv
`timescale 1ns/1ps
module scd_host_model #(
  parameter int DLY = 4
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // One request per DMA channel, one shared hold acknowledge back
  input wire logic [3:0] DMA_REQ,
  output logic HOLD_ACK_IN,
  // Priority pin; low means this device is first in the chain
  output logic INTERRUPT_PRIORITY_IN
);
  int wait_cnt; // Cycles the current request has waited
  // Hold is granted late so the device settles its priority first
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wait_cnt <= 0;
      HOLD_ACK_IN <= 1'b0;
    end else if (DMA_REQ == 4'h0) begin
      // Nothing asked for: release the bus
      wait_cnt <= 0;
      HOLD_ACK_IN <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 1;
      HOLD_ACK_IN <= (wait_cnt >= DLY);
    end
  end
  // Sole device, so the priority input is held active
  assign INTERRUPT_PRIORITY_IN = 1'b0;
endmodule : scd_host_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import scd_pkg::*;
  logic clk, resetn, cyc, stb, we, hold, interrupt_priority_in, ack, int_n, ackn, vec_oe, chan_b_req, chan_b_oe;
  logic [7:0] adr, vec_data;
  logic [31:0] wd, rd, q;
  logic [1:0] cts, tneed, tsent, rchar, rovr, rflag, rabort, send_flag, send_crc;
  logic [15:0] rdata, tbyte;
  logic [5:0] rres;
  logic [3:0] req;
  int mismatches, comparisons, cycles;
  scd_top u_scd_top (.CLK(clk), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(rd),
    .WB_ACK_O(ack), .CTS(cts), .DCD(2'h0), .TX_NEED(tneed), .TX_SENT(tsent),
    .TX_BYTE(tbyte), .TX_SEND_FLAG(send_flag), .TX_SEND_CRC(send_crc), .RX_CHAR(rchar),
    .RX_DATA(rdata), .RX_OVERRUN(rovr), .RX_FLAG(rflag), .RX_ABORT(rabort),
    .RX_RESIDUE(rres), .DMA_REQ(req), .HOLD_ACK_IN(hold), .INT_N(int_n),
    .INTERRUPT_ACK_N(ackn), .INTERRUPT_PRIORITY_IN(interrupt_priority_in), .CHAN_B_RX_DMA_REQ(chan_b_req),
    .CHAN_B_RX_DMA_REQ_OE(chan_b_oe), .VEC_DATA(vec_data), .VEC_OE(vec_oe));
  scd_host_model u_scd_host_model (.CLK(clk), .RESETN(resetn), .DMA_REQ(req),
    .HOLD_ACK_IN(hold), .INTERRUPT_PRIORITY_IN(interrupt_priority_in));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cuts a hang short; the ceiling is far above the fewer than two hundred cycles used
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk
  // One classic Wishbone cycle; entered and left just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    // No local limit: only the cycle ceiling cuts a missing ack short
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  // Transfer under hold; three edges cover the hold synchroniser
  task automatic serve(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    for (n = 0; n < 30 && hold !== 1'b1; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    wb(w, a, d);
  endtask : serve
  // One-cycle strobe: 0 byte wanted, 1 CRC or flag sent, else character in
  task automatic pulse(input int k, input logic [1:0] v);
    case (k)
      0: tneed <= v;
      1: tsent <= v;
      default: rchar <= v;
    endcase
    @(posedge clk);
    {tneed, tsent, rchar} <= '0;
    @(posedge clk);
  endtask : pulse
  // Reset values and an unmapped place
  task automatic t_regs;
    chk(int_n, 32'h1);
    wb(1'b0, A_CTRL, 32'h0);
    chk(q, {24'h0, CTRL_RST});
    wb(1'b1, 8'h3C, 32'hFF);
    wb(1'b0, 8'h3C, 32'h0);
    chk(q, 32'h0);
    $display("test regs done");
  endtask : t_regs
  // Receive under DMA: every-char mode, closing flag, error reset, overrun
  task automatic t_rx;
    wb(1'b1, A_CTRL, 32'h2C);
    rdata <= 16'h005A;
    pulse(2, 2'h1);
    chk(req[1], 32'h1);
    @(posedge clk);
    chk(int_n, 32'h0);
    wb(1'b0, A_RXD, 32'h0);
    chk(req[1], 32'h1);
    serve(1'b0, A_RXD, 32'h0);
    chk(q[7:0], 32'h5A);
    chk(req[1], 32'h0);
    pulse(2, 2'h1);
    rflag <= 2'h1;
    rres <= 6'h05;
    @(posedge clk);
    rflag <= 2'h0;
    @(posedge clk);
    chk(req[1], 32'h0);
    wb(1'b0, A_STS, 32'h0);
    chk({q[8:6], q[3]}, 32'hB);
    wb(1'b1, A_CMD, 32'h1 << K_ERR);
    wb(1'b1, A_STS, 32'h1804);
    wb(1'b0, A_STS, 32'h0);
    chk(q[3], 32'h0);
    chk(int_n, 32'h1);
    {rovr, rabort} <= 4'h5;
    @(posedge clk);
    {rovr, rabort} <= 4'h0;
    @(posedge clk);
    chk(req[1], 32'h1);
    @(posedge clk);
    chk(int_n, 32'h0);
    wb(1'b0, A_STS, 32'h0);
    chk(q[4:3], 32'h3);
    chk(q[S_EXT], 32'h1);
    $display("test rx done");
  endtask : t_rx
  // Transmit under DMA: clear-to-send start, CPU address byte, DMA refill
  task automatic t_tx;
    int n;
    wb(1'b1, A_CTRL, 32'h43);
    cts <= 2'h1;
    for (n = 0; n < 10 && send_flag[0] !== 1'b1; n++) @(posedge clk);
    chk(send_flag[0], 32'h1);
    wb(1'b0, A_STS, 32'h0);
    chk(q[S_EXT], 32'h1);
    wb(1'b1, A_TXD, 32'h0A); // Address byte from the CPU first
    pulse(0, 2'h1);
    chk(req[0], 32'h1);
    wb(1'b0, A_STS, 32'h0);
    chk(q[S_TXI], 32'h0);
    serve(1'b1, A_TXD, 32'h33);
    chk(req[0], 32'h0);
    chk(tbyte[7:0], 32'h33);
    wb(1'b1, A_CMD, 32'h1 << K_EOM); // Latch reset once the first byte is out
    pulse(0, 2'h1);
    pulse(0, 2'h1);
    chk(send_crc[0], 32'h1);
    pulse(1, 2'h1);
    chk({send_flag[0], send_crc[0]}, 32'h2);
    pulse(1, 2'h1);
    wb(1'b0, A_STS, 32'h0);
    chk({q[S_TXI], q[0]}, 32'h3);
    $display("test tx done");
  endtask : t_tx
  // Vectored acknowledge: one byte of the call per acknowledge pulse
  task automatic t_vec;
    logic [7:0] want [3];
    want = '{CALL_OP, 8'hAB, CALL_HI}; // Base A8 with channel A special cause
    wb(1'b1, A_VEC, 32'h1A8);
    for (int i = 0; i < 3; i++) begin
      ackn <= 1'b0;
      repeat (4) @(posedge clk);
      chk({vec_oe, vec_data}, {1'b1, want[i]});
      ackn <= 1'b1;
      repeat (4) @(posedge clk);
      chk(vec_oe, 32'h0);
    end
    $display("test vec done");
  endtask : t_vec
  // Channel B in first-character mode, then both channels under receive DMA
  task automatic t_first;
    wb(1'b1, 8'h04, 32'h1C);
    wb(1'b1, A_CMD, 32'h1 << (K_NEXT + 1));
    pulse(2, 2'h2);
    chk(req[3], 32'h1);
    wb(1'b0, 8'h1C, 32'h0);
    chk(q[S_RXI], 32'h1);
    wb(1'b1, 8'h1C, 32'h1000);
    pulse(2, 2'h2);
    wb(1'b0, 8'h1C, 32'h0);
    chk(q[S_RXI], 32'h0);
    chk(req[3], 32'h1);
    wb(1'b1, A_CTRL, 32'h0C);
    chk({chan_b_oe, chan_b_req}, 32'h3);
    $display("test first done");
  endtask : t_first
  // Verdict, the single place the run ends
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    {resetn, cyc, stb, we, adr, wd} = '0;
    {cts, tneed, tsent, rchar, rovr, rflag, rabort, rdata, rres} = '0;
    ackn = 1'b1;
    {mismatches, comparisons, cycles} = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_rx();
    t_tx();
    t_vec();
    t_first();
    tally_and_finish();
  end
endmodule : tb
